//--- ppf_regs.svh
// register offsets, field positions and reset values of the pulse-width unit
`ifndef PPF_REGS_SVH
`define PPF_REGS_SVH
`define PPF_CTL_OFF 12'h000
`define PPF_UPD_OFF 12'h004
`define PPF_MIEN_OFF 12'h008
`define PPF_MRIS_OFF 12'h00C
`define PPF_MMIS_OFF 12'h010
`define PPF_FSUP_OFF 12'h014
`define PPF_FLVL_OFF 12'h018
`define PPF_INV_OFF 12'h01C
`define PPF_FLT_OFF 12'h020
`define PPF_GEN_BASE 12'h040
`define PPF_GEN_STRIDE 12'h020
`define PPF_G_LOAD 5'h00
`define PPF_G_CMPA 5'h04
`define PPF_G_CMPB 5'h08
`define PPF_G_INTEN 5'h0C
`define PPF_G_RIS 5'h10
`define PPF_G_MIS 5'h14
`define PPF_G_CNT 5'h18
`define PPF_LOAD_RST 16'h00FF
`define PPF_EV_ZERO 0
`define PPF_EV_LOAD 1
`define PPF_EV_AU 2
`define PPF_EV_AD 3
`define PPF_EV_BU 4
`define PPF_EV_BD 5
`define PPF_TRG_SHIFT 8
`endif

//--- ppf_pkg.sv
// types shared by the pulse-width unit
package ppf_pkg;
    typedef logic [5:0] ppf_ev_t;   // six generator events
    typedef logic [15:0] ppf_cnt_t; // counter and period width
endpackage

//--- ppf_gen.sv
// one generator: up/down counter with buffered period and comparators
`timescale 1ns/1ps
`default_nettype none
`include "ppf_regs.svh"
module ppf_gen (
    input wire logic clk,
    input wire logic nrst,
    input wire logic en,
    input wire ppf_pkg::ppf_cnt_t load_pend,
    input wire ppf_pkg::ppf_cnt_t cmpa_pend,
    input wire ppf_pkg::ppf_cnt_t cmpb_pend,
    input wire logic upd_arm,
    output logic upd_done,
    output ppf_pkg::ppf_cnt_t cnt,
    output ppf_pkg::ppf_ev_t ev,
    output logic pwm_a,
    output logic pwm_b
);
    import ppf_pkg::*;
    ppf_cnt_t load_q, cmpa_q, cmpb_q, cnt_q; // active values and counter
    logic down_q;                             // counting direction
    logic arm_q;                              // pending update armed
    logic at_zero, at_load;
    assign at_zero = (cnt_q == 16'h0000);
    assign at_load = (cnt_q >= load_q);
    assign cnt = cnt_q;
    assign upd_done = en & at_zero & arm_q;

    // up/down count; ticks between zero pulses are twice the period
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= 16'h0000;
            down_q <= 1'b0;
        end else if (en) begin
            if (!down_q && at_load) begin
                down_q <= 1'b1;
                cnt_q <= cnt_q - 16'h0001;
            end else if (down_q && at_zero) begin
                down_q <= 1'b0;
                cnt_q <= 16'h0001;
            end else if (down_q) begin
                cnt_q <= cnt_q - 16'h0001;
            end else begin
                cnt_q <= cnt_q + 16'h0001;
            end
        end
    end

    // queued values move to active at counter zero once an update strobe has armed them
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            load_q <= `PPF_LOAD_RST;
            cmpa_q <= 16'h0000;
            cmpb_q <= 16'h0000;
            arm_q <= 1'b0;
        end else if (en) begin
            if (upd_done) begin
                load_q <= load_pend;
                cmpa_q <= cmpa_pend;
                cmpb_q <= cmpb_pend;
                arm_q <= 1'b0;
            end else if (upd_arm) begin
                arm_q <= 1'b1;
            end
        end
    end

    // events and raw waveforms
    always_comb begin
        ev = 6'h00;
        ev[`PPF_EV_ZERO] = at_zero;
        ev[`PPF_EV_LOAD] = (cnt_q == load_q);
        ev[`PPF_EV_AU] = !down_q && (cnt_q == cmpa_q);
        ev[`PPF_EV_AD] = down_q && (cnt_q == cmpa_q);
        ev[`PPF_EV_BU] = !down_q && (cnt_q == cmpb_q);
        ev[`PPF_EV_BD] = down_q && (cnt_q == cmpb_q);
        pwm_a = (cnt_q < cmpa_q);
        pwm_b = (cnt_q < cmpb_q);
    end
endmodule // ppf_gen
`default_nettype wire

//--- ppf_top.sv
// pulse-width unit: register file, interrupts, fault and polarity stage
//
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "ppf_regs.svh"
// Operation
// - per-generator interrupt and trigger enables
// - ticks between zero pulses equal twice the period
// - period read returns last programmed value
// - later buffered writes replace pending value
// - module enable bit per generator, fault
// - set enable bit unmasks that source
// - raw and masked module status offered
// - fault forces selected outputs inactive
// - default suppressed level is low
// - drive-high selection drives suppressed high
// - level selection ignored when not suppressed
// - inversion selection makes output active low
// - write one clears generator status bit
// - queued updates applied at counter zero
module ppf_top #(
    parameter int NGEN = 4
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [3:0] fault_in,
    output logic [7:0] pwm_out,
    output logic [3:0] trig_out,
    output logic irq
);
    import ppf_pkg::*;

    // decode a generator-window address to its index, or 7 when outside
    function automatic logic [2:0] gen_idx(input logic [11:0] a);
        logic [11:0] rel;
        rel = a - `PPF_GEN_BASE;
        if (a >= `PPF_GEN_BASE && rel < 12'(NGEN * `PPF_GEN_STRIDE))
            gen_idx = rel[7:5];
        else
            gen_idx = 3'h7;
    endfunction

    logic wr, rd;
    assign wr = ce & psel & penable & pwrite;
    // read data is launched in the setup cycle so it stands with pready
    assign rd = ce & psel & ~penable & ~pwrite;
    logic [2:0] gi;
    logic [4:0] go;
    assign gi = gen_idx(paddr);
    assign go = paddr[4:0];

    ppf_cnt_t load_p_q [NGEN];  // programmed period, read back
    ppf_cnt_t cmpa_p_q [NGEN];
    ppf_cnt_t cmpb_p_q [NGEN];
    logic [15:0] inten_q [NGEN]; // low: irq enables, high: trigger enables
    ppf_ev_t gris_q [NGEN];      // generator raw status
    logic [3:0] gen_run_q;       // generator run enables
    logic [3:0] upd_req;         // update strobe from software
    logic [3:0] upd_done;
    logic [7:0] mien_q;          // module irq enable
    logic [3:0] fris_q;          // fault raw status
    logic [7:0] fsup_q, flvl_q, inv_q;
    logic [3:0] fflt_q;          // fault stage sample
    ppf_cnt_t gcnt [NGEN];
    ppf_ev_t gev [NGEN];
    logic [7:0] raw_pwm;
    logic [7:0] mris;
    logic [3:0] fault_act;

    assign upd_req = (wr && paddr == `PPF_UPD_OFF) ? pwdata[3:0] : 4'h0;

    // generators
    genvar g;
    generate
        for (g = 0; g < NGEN; g++) begin : gen_blk
            ppf_gen u_gen (
                .clk(clk),
                .nrst(nrst),
                .en(ce & gen_run_q[g]),
                .load_pend(load_p_q[g]),
                .cmpa_pend(cmpa_p_q[g]),
                .cmpb_pend(cmpb_p_q[g]),
                .upd_arm(upd_req[g]),
                .upd_done(upd_done[g]),
                .cnt(gcnt[g]),
                .ev(gev[g]),
                .pwm_a(raw_pwm[2*g]),
                .pwm_b(raw_pwm[2*g+1])
            );
            // software values; last write wins until update applies
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    load_p_q[g] <= `PPF_LOAD_RST;
                    cmpa_p_q[g] <= 16'h0000;
                    cmpb_p_q[g] <= 16'h0000;
                    inten_q[g] <= 16'h0000;
                end else if (wr && gi == 3'(g)) begin
                    case (go)
                        `PPF_G_LOAD: load_p_q[g] <= pwdata[15:0];
                        `PPF_G_CMPA: cmpa_p_q[g] <= pwdata[15:0];
                        `PPF_G_CMPB: cmpb_p_q[g] <= pwdata[15:0];
                        `PPF_G_INTEN: inten_q[g] <= pwdata[15:0];
                        default: ;
                    endcase
                end
            end
            // sticky event status; set beats write-one clear
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    gris_q[g] <= 6'h00;
                end else if (ce) begin
                    gris_q[g] <= (gris_q[g] & ~((wr && gi == 3'(g)
                        && go == `PPF_G_RIS) ? pwdata[5:0] : 6'h00))
                        | (gen_run_q[g] ? gev[g] : 6'h00);
                end
            end
            // triggers gated by the trigger enables
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst)
                    trig_out[g] <= 1'b0;
                else if (ce)
                    trig_out[g] <= gen_run_q[g] & |(gev[g]
                        & inten_q[g][`PPF_TRG_SHIFT +: 6]);
            end
            assign mris[g] = |(gris_q[g] & inten_q[g][5:0]);
        end
    endgenerate
    assign mris[7:4] = fris_q;

    // module control registers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            gen_run_q <= 4'h0;
            mien_q <= 8'h00;
            fsup_q <= 8'h00;
            flvl_q <= 8'h00;
            inv_q <= 8'h00;
        end else if (wr) begin
            case (paddr)
                `PPF_CTL_OFF: gen_run_q <= pwdata[3:0];
                `PPF_MIEN_OFF: mien_q <= pwdata[7:0];
                `PPF_FSUP_OFF: fsup_q <= pwdata[7:0];
                `PPF_FLVL_OFF: flvl_q <= pwdata[7:0];
                `PPF_INV_OFF: inv_q <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    // fault status: sticky on input, write one clears, set wins
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fris_q <= 4'h0;
            fflt_q <= 4'h0;
        end else if (ce) begin
            fflt_q <= fault_in;
            fris_q <= (fris_q & ~((wr && paddr == `PPF_MRIS_OFF)
                ? pwdata[7:4] : 4'h0)) | fault_in;
        end
    end
    assign fault_act = fflt_q;

    // output stage: suppressed bits take the level, others the polarity
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pwm_out <= 8'h00;
        end else if (ce) begin
            for (int i = 0; i < 8; i++) begin
                if (|fault_act && fsup_q[i])
                    pwm_out[i] <= flvl_q[i];
                else
                    pwm_out[i] <= raw_pwm[i] ^ inv_q[i];
            end
        end
    end

    // interrupt line from masked status
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            irq <= 1'b0;
        else if (ce)
            irq <= |(mris & mien_q);
    end

    // apb read mux; one wait-free access phase
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (ce) begin
            pready <= psel & ~penable;
            pslverr <= 1'b0;
            if (rd) begin
                prdata <= 32'h0000_0000;
                if (gi != 3'h7) begin
                    case (go)
                        `PPF_G_LOAD: prdata[15:0] <= load_p_q[gi[1:0]];
                        `PPF_G_CMPA: prdata[15:0] <= cmpa_p_q[gi[1:0]];
                        `PPF_G_CMPB: prdata[15:0] <= cmpb_p_q[gi[1:0]];
                        `PPF_G_INTEN: prdata[15:0] <= inten_q[gi[1:0]];
                        `PPF_G_RIS: prdata[5:0] <= gris_q[gi[1:0]];
                        `PPF_G_MIS: prdata[5:0] <= gris_q[gi[1:0]]
                            & inten_q[gi[1:0]][5:0];
                        `PPF_G_CNT: prdata[15:0] <= gcnt[gi[1:0]];
                        default: ;
                    endcase
                end else begin
                    case (paddr)
                        `PPF_CTL_OFF: prdata[3:0] <= gen_run_q;
                        `PPF_MIEN_OFF: prdata[7:0] <= mien_q;
                        `PPF_MRIS_OFF: prdata[7:0] <= mris;
                        `PPF_MMIS_OFF: prdata[7:0] <= mris & mien_q;
                        `PPF_FSUP_OFF: prdata[7:0] <= fsup_q;
                        `PPF_FLVL_OFF: prdata[7:0] <= flvl_q;
                        `PPF_INV_OFF: prdata[7:0] <= inv_q;
                        `PPF_FLT_OFF: prdata[3:0] <= fflt_q;
                        default: ;
                    endcase
                end
            end
        end
    end
endmodule // ppf_top
`default_nettype wire

//--- ppf_top_properties.sv
// port-level checks of the pulse-width unit
`timescale 1ns/1ps
`default_nettype none
`include "ppf_regs.svh"
module ppf_top_properties #(
    parameter int NGEN = 4
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [3:0] fault_in,
    input wire logic [7:0] pwm_out,
    input wire logic [3:0] trig_out,
    input wire logic irq
);
    logic [7:0] sup_q; // mirrored suppress selection
    logic [7:0] lvl_q; // mirrored drive-high selection
    logic [2:0] age_q; // cycles since the last write
    logic wr_done; // a write completes at this edge
    assign wr_done = psel && penable && pready && pwrite;
    // mirror fault settings so outputs can be judged in a fault
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sup_q <= 8'h00;
            lvl_q <= 8'h00;
            age_q <= 3'h0;
        end else begin
            if (wr_done && paddr == `PPF_FSUP_OFF) begin
                sup_q <= pwdata[7:0];
            end
            if (wr_done && paddr == `PPF_FLVL_OFF) begin
                lvl_q <= pwdata[7:0];
            end
            if (wr_done) begin
                age_q <= 3'h0;
            end else if (age_q != 3'h7) begin
                age_q <= age_q + 3'h1;
            end
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    ready_after_setup_a: assert property (psel && !penable && ce |=> pready)
        else $error("no ready after setup");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    ready_in_access_a: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    no_bus_error_a: assert property (pready |-> !pslverr)
        else $error("error response seen");
    read_data_hold_a: assert property ($changed(prdata) |-> pready && !pwrite)
        else $error("read data moved without a read");
    freeze_hold_a: assert property (!ce |=> $stable(pwm_out) && $stable(trig_out))
        else $error("outputs moved while frozen");
    fault_level_a: assert property (age_q == 3'h7 && ce && (|fault_in)
        && $past(|fault_in) && $past(|fault_in, 2)
        |-> (pwm_out & sup_q) == (lvl_q & sup_q)) else $error("bad fault level");
    reset_quiet_a: assert property (disable iff (1'b0) !nrst && $past(!nrst)
        |-> pwm_out == 8'h00 && irq == 1'b0) else $error("outputs live in reset");
endmodule // ppf_top_properties
bind ppf_top ppf_top_properties #(.NGEN(NGEN)) u_props (.*);
`default_nettype wire

//--- ppf_stage_model.sv
// power stage and fault source at the output pins
`timescale 1ns/1ps
`default_nettype none
module ppf_stage_model (
    input wire logic clk,
    input wire logic [7:0] pwm_out,
    input wire logic [3:0] fault_req,
    output logic [3:0] fault_in
);
    logic [3:0] flt_q = 4'h0; // fault lines, synchronous to clk
    logic [7:0] gate_q = 8'h00; // last gate levels taken by the stage
    assign fault_in = flt_q;
    // the stage reports faults one clock after they arise
    always_ff @(posedge clk) begin
        flt_q <= fault_req;
        gate_q <= pwm_out;
    end
endmodule // ppf_stage_model
`default_nettype wire

//--- tb_pwm_period_fault_output_ctrl.sv
// self-checking bench of the pulse-width unit
`timescale 1ns/1ps
`default_nettype none
`include "ppf_regs.svh"
module tb_pwm_period_fault_output_ctrl;
    import ppf_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b1; // falls at time zero to start the reset
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [3:0] fault_req = 4'h0;
    logic [3:0] fault_in;
    logic [7:0] pwm_out;
    logic [3:0] trig_out;
    logic irq;
    logic [31:0] exp_q[$]; // expected read data, oldest first
    logic [7:0] s, l, v, m;
    int fails = 0;
    int cmp_count = 0;
    int f, gap;
    localparam logic [11:0] G0 = `PPF_GEN_BASE;
    always #5 clk = ~clk;
    ppf_top #(.NGEN(4)) u_dut (.*);
    ppf_stage_model u_stage (.*);
    task automatic report_and_stop();
        if (fails == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, exp, input string nm);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one transfer; the next call or cyc releases the bus
    task automatic apb(input logic w, input logic [11:0] a, input int d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            fails++;
            report_and_stop();
        end
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 0);
    endtask
    task automatic cyc(input int n);
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (n) @(posedge clk);
    endtask
    // cycles up to the next counter-zero trigger of generator 0
    task automatic zgap(output int n);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (trig_out[0] !== 1'b1 && n < 3000);
        if (n >= 3000) begin
            fails++;
            report_and_stop();
        end
    endtask
    // read results are matched against the oldest note
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            chk(prdata, exp_q.pop_front(), "prdata");
        end
    end
    initial begin
        void'($urandom(12715));
        nrst <= 1'b0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rd(12'h3FC, 0);
        apb(1'b1, 12'h3FC, $urandom);
        rd(12'h3FC, 0);
        for (int i = 0; i < 4; i++) begin
            s = 8'($urandom);
            l = 8'($urandom);
            v = 8'($urandom);
            m = 8'($urandom);
            f = $urandom_range(3, 0);
            apb(1'b1, `PPF_MIEN_OFF, m);
            apb(1'b1, `PPF_FSUP_OFF, s);
            apb(1'b1, `PPF_FLVL_OFF, l);
            apb(1'b1, `PPF_INV_OFF, v);
            cyc(8);
            chk(32'(pwm_out), 32'(v), "pwm_out");
            fault_req <= 4'h1 << f;
            repeat (5) @(posedge clk);
            chk(32'(pwm_out), 32'((s & l) | (~s & v)), "fault");
            fault_req <= 4'h0;
            repeat (4) @(posedge clk);
            rd(`PPF_MRIS_OFF, 32'h1 << (4 + f));
            rd(`PPF_MMIS_OFF, 32'(m) & (32'h1 << (4 + f)));
            rd(`PPF_MIEN_OFF, 32'(m));
            cyc(1);
            chk(32'(irq), 32'(m[4 + f]), "irq");
            apb(1'b1, `PPF_MRIS_OFF, 32'hF0);
            rd(`PPF_MRIS_OFF, 0);
            cyc(3);
            chk(32'(irq), 0, "irq");
        end
        apb(1'b1, G0 + `PPF_G_INTEN, 32'h0101);
        apb(1'b1, G0 + `PPF_G_LOAD, 32'h0040 + $urandom_range(255, 0));
        apb(1'b1, G0 + `PPF_G_LOAD, 32'h0020);
        rd(G0 + `PPF_G_LOAD, 32'h0020);
        apb(1'b1, `PPF_MIEN_OFF, 32'h1);
        apb(1'b1, `PPF_CTL_OFF, 32'h1);
        apb(1'b1, `PPF_UPD_OFF, 32'h1);
        cyc(1);
        repeat (3) zgap(gap);
        chk(gap, 64, "period");
        apb(1'b1, G0 + `PPF_G_LOAD, 32'h0030);
        rd(G0 + `PPF_G_LOAD, 32'h0030);
        cyc(1);
        repeat (2) zgap(gap);
        chk(gap, 64, "pending period");
        chk(32'(irq), 1, "irq");
        rd(G0 + `PPF_G_MIS, 32'h1);
        apb(1'b1, `PPF_UPD_OFF, 32'h1);
        cyc(1);
        repeat (3) zgap(gap);
        chk(gap, 96, "period");
        apb(1'b1, `PPF_CTL_OFF, 0);
        apb(1'b1, G0 + `PPF_G_RIS, 32'h3F);
        rd(G0 + `PPF_G_RIS, 0);
        ce <= 1'b0;
        cyc(3);
        ce <= 1'b1;
        cyc(2);
        chk(32'(irq), 0, "irq");
        report_and_stop();
    end
endmodule // tb_pwm_period_fault_output_ctrl
`default_nettype wire
